// [src/acc_adder.sv]
// Eight-bit adder with overflow, half-carry and carry.
// Purely combinational; the caller registers its results.
`timescale 1ns/1ps
module acc_adder
   import acc_alu_pkg::*;
(
   input  wire logic [7:0] a_in,
   input  wire logic [7:0] b_in,
   input  wire logic       cin_in,
   output logic      [7:0] sum_out,
   output logic            ovf_out,
   output logic            half_out,
   output logic            carry_out
);
   logic [NIB_W:0]  low_nib;
   logic [DATA_W:0] full;

   always_comb
   begin
      low_nib   = {1'b0, a_in[HALF_BIT:0]} + {1'b0, b_in[HALF_BIT:0]}
                  + {{NIB_W{1'b0}}, cin_in};
      full      = {1'b0, a_in} + {1'b0, b_in} + {{DATA_W{1'b0}}, cin_in};
      sum_out   = full[DATA_W-1:0];
      half_out  = low_nib[NIB_W];
      carry_out = full[DATA_W];
      // Signed overflow: like-signed operands, differently signed sum
      ovf_out   = (a_in[CARRY_BIT] == b_in[CARRY_BIT])
                  && (sum_out[CARRY_BIT] != a_in[CARRY_BIT]);
   end
endmodule : acc_adder

// [src/acc_alu_pkg.sv]
// Shared types and constants for the accumulator datapath.
// Assumes a single core clock; no bus, all controls are plain ports.
package acc_alu_pkg;

   localparam int DATA_W      = 8;
   localparam int CARRY_BIT   = 7;
   localparam int HALF_BIT    = 3;
   localparam int NIB_W       = 4;
   localparam int LONG_CYCLES = 2;
   localparam int SHORT_CYCLES = 1;
   localparam logic [7:0] ACC_RESET = 8'h00;

   typedef enum logic [3:0] {
      OP_NONE     = 4'h0,
      OP_ADC_ACC  = 4'h1,
      OP_ADC_MEM  = 4'h2,
      OP_ADD_ACC  = 4'h3,
      OP_ADD_IMM  = 4'h4,
      OP_ADD_MEM  = 4'h5,
      OP_AND_ACC  = 4'h6,
      OP_AND_IMM  = 4'h7,
      OP_AND_MEM  = 4'h8,
      OP_WDT_PRE1 = 4'h9,
      OP_WDT_PRE2 = 4'hA,
      OP_SKIP     = 4'hB,
      OP_PCLOW_WR = 4'hC
   } alu_op_e;

   typedef struct packed {
      alu_op_e     op;
      logic [7:0]  mem_operand;
      logic [7:0]  literal;
      logic        skip_taken;
   } alu_req_s;

   typedef struct packed {
      logic overflow_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } alu_flags_s;

endpackage : acc_alu_pkg

// [src/accumulator_add_and_alu.sv]
// Accumulator add, add-with-carry and AND datapath with cycle counts.
// Assumes the sequencer issues one request per free cycle and holds
// off while busy_out is high; memory writes are one-cycle strobes.
//
// Overview of operation
// - Taken skip costs two cycles; untaken skip costs one.
// - Instruction writing program counter low byte costs two cycles.
// - Both pre-clears in a row clear timeout and power-down flags.
// - Unpaired pre-clear leaves timeout and power-down flags unchanged.
// - Add-with-carry to accumulator: sum plus carry in, updates four flags.
// - Add-with-carry to memory: sum plus carry stored, updates four flags.
// - Add to accumulator: acc+mem without carry, updates four flags.
// - Immediate add: acc+literal into accumulator, updates four flags.
// - Add to memory: acc+mem stored in memory, updates four flags.
// - AND to accumulator: acc&mem, only zero flag changes.
// - Immediate AND: acc&literal into accumulator, only zero flag.
// - AND to memory: acc&mem stored in memory, only zero flag.
// - Pre-clears act only when alternated; repeats have no effect.
`timescale 1ns/1ps
module accumulator_add_and_alu
   import acc_alu_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       clk_en_in,
   input  wire logic       req_valid_in,
   input  wire alu_req_s   req_in,
   output logic      [7:0] accumulator_out,
   output alu_flags_s      flags_out,
   output logic            mem_wr_out,
   output logic      [7:0] mem_wdata_out,
   output logic            watchdog_timeout_flag_out,
   output logic            power_down_flag_out,
   output logic            wdt_clear_out,
   output logic            busy_out,
   input  wire logic       set_timeout_in,
   input  wire logic       set_power_down_in
);

   ////////////////////////////////////////////////////////////////////
   // Adder and request decode

   logic [7:0] add_b;
   logic       add_cin;
   logic [7:0] sum;
   logic       ovf;
   logic       half;
   logic       cry;
   logic       take;
   logic       pre1;
   logic       pre2;
   logic       pair_clear;

   assign take = req_valid_in && !busy_out;
   assign pre1 = take && (req_in.op == OP_WDT_PRE1);
   assign pre2 = take && (req_in.op == OP_WDT_PRE2);

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction : is_zero

   always_comb
   begin
      add_b   = (req_in.op == OP_ADD_IMM) ? req_in.literal
                                          : req_in.mem_operand;
      add_cin = 1'b0;
      if (req_in.op == OP_ADC_ACC || req_in.op == OP_ADC_MEM)
         add_cin = flags_out.carry_flag;
   end

   acc_adder u_adder
   (
      .a_in      (accumulator_out),
      .b_in      (add_b),
      .cin_in    (add_cin),
      .sum_out   (sum),
      .ovf_out   (ovf),
      .half_out  (half),
      .carry_out (cry)
   );

   wdt_preclear_pair u_pair
   (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .clk_en_in  (clk_en_in),
      .pre1_in    (pre1),
      .pre2_in    (pre2),
      .other_in   (take && !pre1 && !pre2),
      .clear_out  (pair_clear)
   );

   ////////////////////////////////////////////////////////////////////
   // Datapath next state

   logic [7:0] acc_d;
   alu_flags_s flg_d;
   logic       mwr_d;
   logic [7:0] mdat_d;
   logic       to_d;
   logic       pdn_d;
   logic       clr_d;
   logic [7:0] and_r;

   always_comb
   begin
      acc_d  = accumulator_out;
      flg_d  = flags_out;
      mwr_d  = 1'b0;
      mdat_d = mem_wdata_out;
      clr_d  = 1'b0;
      and_r  = accumulator_out & ((req_in.op == OP_AND_IMM)
                                  ? req_in.literal : req_in.mem_operand);
      if (take)
      begin
         unique case (req_in.op)
            OP_ADC_ACC, OP_ADD_ACC, OP_ADD_IMM:
            begin
               acc_d = sum;
               flg_d = '{ovf, is_zero(sum), half, cry};
            end
            OP_ADC_MEM, OP_ADD_MEM:
            begin
               mwr_d  = 1'b1;
               mdat_d = sum;
               flg_d  = '{ovf, is_zero(sum), half, cry};
            end
            OP_AND_ACC, OP_AND_IMM:
            begin
               acc_d = and_r;
               flg_d.zero_flag = is_zero(and_r);
            end
            OP_AND_MEM:
            begin
               mwr_d  = 1'b1;
               mdat_d = and_r;
               flg_d.zero_flag = is_zero(and_r);
            end
            OP_WDT_PRE1, OP_WDT_PRE2:
               clr_d = pair_clear;
            default:
               ;
         endcase
      end
      // Clear from a completed pair, else hardware sets persist
      to_d  = pair_clear ? 1'b0 : watchdog_timeout_flag_out;
      pdn_d = pair_clear ? 1'b0 : power_down_flag_out;
      // Set wins over a same-cycle clear
      if (set_timeout_in)
         to_d = 1'b1;
      if (set_power_down_in)
         pdn_d = 1'b1;
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         accumulator_out           <= ACC_RESET;
         flags_out                 <= '0;
         mem_wr_out                <= 1'b0;
         mem_wdata_out             <= ACC_RESET;
         watchdog_timeout_flag_out <= 1'b0;
         power_down_flag_out       <= 1'b0;
         wdt_clear_out             <= 1'b0;
      end
      else if (clk_en_in)
      begin
         accumulator_out           <= acc_d;
         flags_out                 <= flg_d;
         mem_wr_out                <= mwr_d;
         mem_wdata_out             <= mdat_d;
         watchdog_timeout_flag_out <= to_d;
         power_down_flag_out       <= pdn_d;
         wdt_clear_out             <= clr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Cycle-count sequencer

   typedef enum logic [1:0] {
      ST_FREE  = 2'b00,
      ST_EXTRA = 2'b01
   } cyc_state_e;

   cyc_state_e st_q;
   cyc_state_e st_d;
   logic       long_op;

   // Extra cycle flushes the prefetched instruction
   assign long_op = take && ((req_in.op == OP_SKIP && req_in.skip_taken)
                             || req_in.op == OP_PCLOW_WR);

   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         ST_FREE:  if (long_op) st_d = ST_EXTRA;
         ST_EXTRA: st_d = ST_FREE;
         default:  st_d = ST_FREE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st_q     <= ST_FREE;
         busy_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         st_q     <= st_d;
         busy_out <= (st_d == ST_EXTRA);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_skip_two_cycles: assert property (clk_en_in && take
      && req_in.op == OP_SKIP && req_in.skip_taken |=>
      busy_out) else $error("taken skip not two cycles");
   a_skip_one_cycle: assert property (clk_en_in && take
      && req_in.op == OP_SKIP && !req_in.skip_taken |=>
      !busy_out) else $error("untaken skip stalled");
   a_pc_low_two: assert property (clk_en_in && take
      && req_in.op == OP_PCLOW_WR |=> busy_out ##1
      (!busy_out || !$past(clk_en_in)))
      else $error("program counter write not two cycles");
   a_busy_one_cycle: assert property (clk_en_in && busy_out
      |=> !busy_out) else $error("extra cycle stretched");
   a_busy_refuses: assert property (clk_en_in && busy_out
      && req_valid_in |=> !mem_wr_out
      && accumulator_out == $past(accumulator_out))
      else $error("request taken while busy");
   a_pair_clears: assert property (clk_en_in && pre1 ##1 clk_en_in
      && pre2 && !set_timeout_in |=> !watchdog_timeout_flag_out)
      else $error("pair did not clear timeout");
   a_reversed_pair: assert property (clk_en_in && pre2 ##1 clk_en_in
      && pre1 && !set_power_down_in |=> !power_down_flag_out)
      else $error("reversed pair did not clear power down");
   a_repeat_no_clear: assert property (clk_en_in && pre1 ##1
      clk_en_in && pre1 |-> !pair_clear)
      else $error("repeated preclear cleared");
   a_repeat_keeps: assert property (clk_en_in && pre1 ##1 clk_en_in
      && pre1 && !set_timeout_in |=> watchdog_timeout_flag_out
      == $past(watchdog_timeout_flag_out))
      else $error("repeated preclear changed timeout");
   a_unpaired_keeps: assert property (clk_en_in && !pair_clear
      && power_down_flag_out |=> power_down_flag_out)
      else $error("power down flag lost");
   a_add_result: assert property (clk_en_in && take
      && req_in.op == OP_ADD_IMM |=> accumulator_out ==
      8'($past(accumulator_out) + $past(req_in.literal)))
      else $error("immediate add wrong");
   a_add_acc_result: assert property (clk_en_in && take
      && req_in.op == OP_ADD_ACC |=> accumulator_out ==
      8'($past(accumulator_out) + $past(req_in.mem_operand)))
      else $error("add to accumulator wrong");
   a_adc_acc_result: assert property (clk_en_in && take
      && req_in.op == OP_ADC_ACC |=> accumulator_out ==
      8'($past(accumulator_out) + $past(req_in.mem_operand)
      + {7'h00, $past(flags_out.carry_flag)}))
      else $error("add with carry to accumulator wrong");
   a_adc_mem_write: assert property (clk_en_in && take
      && req_in.op == OP_ADC_MEM |=> mem_wr_out && mem_wdata_out ==
      8'($past(accumulator_out) + $past(req_in.mem_operand)
      + {7'h00, $past(flags_out.carry_flag)}))
      else $error("adc to memory wrong");
   a_add_mem_write: assert property (clk_en_in && take
      && req_in.op == OP_ADD_MEM |=> mem_wr_out && mem_wdata_out ==
      8'($past(accumulator_out) + $past(req_in.mem_operand))
      && accumulator_out == $past(accumulator_out))
      else $error("add to memory wrong");
   a_and_acc_result: assert property (clk_en_in && take
      && req_in.op == OP_AND_ACC |=> accumulator_out ==
      ($past(accumulator_out) & $past(req_in.mem_operand))
      && flags_out.carry_flag == $past(flags_out.carry_flag))
      else $error("and to accumulator wrong");
   a_and_imm_result: assert property (clk_en_in && take
      && req_in.op == OP_AND_IMM |=> accumulator_out ==
      ($past(accumulator_out) & $past(req_in.literal))
      && flags_out.overflow_flag == $past(flags_out.overflow_flag))
      else $error("immediate and wrong");
   a_and_flags_kept: assert property (clk_en_in && take
      && req_in.op == OP_AND_MEM |=> mem_wr_out
      && flags_out.carry_flag == $past(flags_out.carry_flag)
      && flags_out.half_carry_flag == $past(flags_out.half_carry_flag)
      && flags_out.overflow_flag == $past(flags_out.overflow_flag))
      else $error("and changed carry");

   c_pair: cover property (pre1 ##1 pre2);
   c_skip: cover property (take && req_in.op == OP_SKIP
      && req_in.skip_taken);
   c_adc_carry: cover property (take && req_in.op == OP_ADC_ACC && cry);
   c_refused: cover property (busy_out && req_valid_in);
   c_mem_write: cover property (mem_wr_out);

endmodule : accumulator_add_and_alu

// [src/wdt_preclear_pair.sv]
// Tracks alternation of the two watchdog pre-clear instructions.
// Assumes one-cycle instruction strobes from the sequencer.
`timescale 1ns/1ps
module wdt_preclear_pair
   import acc_alu_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   input  wire logic clk_en_in,
   input  wire logic pre1_in,
   input  wire logic pre2_in,
   input  wire logic other_in,
   output logic      clear_out
);
   // Last executed pre-clear: 0 none, 1 first, 2 second
   logic [1:0] last_q;
   logic [1:0] last_d;

   always_comb
   begin
      last_d    = last_q;
      clear_out = 1'b0;
      if (pre1_in)
      begin
         clear_out = (last_q == 2'h2);
         last_d    = 2'h1;
      end
      else if (pre2_in)
      begin
         clear_out = (last_q == 2'h1);
         last_d    = 2'h2;
      end
      else if (other_in)
         // Any other taken instruction breaks the pair
         last_d = 2'h0;
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         last_q <= 2'h0;
      else if (clk_en_in)
         last_q <= last_d;
   end
endmodule : wdt_preclear_pair

// [tb/data_mem_model.sv]
// Data memory stand-in: keeps the last byte the datapath wrote back.
// Assumes one-cycle write strobes on the core clock.
`timescale 1ns/1ps
module data_mem_model
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] stored_out,
   output int              wr_count_out
);
   // Counts strobes so a stretched pulse shows up as a double write
   always_ff @(posedge ref_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         stored_out   <= 8'h00;
         wr_count_out <= 0;
      end
      else if (wr_in)
      begin
         stored_out   <= wdata_in;
         wr_count_out <= wr_count_out + 1;
      end
   end
endmodule : data_mem_model

// [tb/tb.sv]
// Self-checking bench for the accumulator datapath.
// Assumes the package types; drives inputs on the falling edge.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
   import acc_alu_pkg::*;
   logic       clk, rst_b, clk_en, req_valid, set_to, set_pd;
   alu_req_s   req;
   logic [7:0] acc, wdata, stored;
   alu_flags_s flags, e_f;
   logic       mem_wr, to_f, pd_f, wdt_clr, busy;
   logic [7:0] e_acc;
   int         wr_cnt, n_mismatch, n_checks, cyc;

   accumulator_add_and_alu DUT (.ref_clk_in(clk), .rst_b_in(rst_b),
      .clk_en_in(clk_en), .req_valid_in(req_valid), .req_in(req),
      .accumulator_out(acc), .flags_out(flags), .mem_wr_out(mem_wr),
      .mem_wdata_out(wdata), .watchdog_timeout_flag_out(to_f),
      .power_down_flag_out(pd_f), .wdt_clear_out(wdt_clr),
      .busy_out(busy), .set_timeout_in(set_to),
      .set_power_down_in(set_pd));
   data_mem_model mem0 (.ref_clk_in(clk), .rst_b_in(rst_b),
      .wr_in(mem_wr), .wdata_in(wdata), .stored_out(stored),
      .wr_count_out(wr_cnt));

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (n_mismatch == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   // Called at a falling edge; returns at the next falling edge, half a cycle after the taking edge
   task automatic issue(input alu_op_e op, input logic [7:0] m, x,
                        input logic sk);
      req_valid = 1'b1;
      req = '{op, m, x, sk};
      @(negedge clk);
      req_valid = 1'b0;
   endtask : issue

   task automatic arith(input alu_op_e op, input logic [7:0] m, x);
      logic [7:0] b, r, lo;
      logic [8:0] s;
      logic [4:0] h;
      logic       cin, is_mem;
      int         wc;
      b = (op == OP_ADD_IMM || op == OP_AND_IMM) ? x : m;
      cin = (op == OP_ADC_ACC || op == OP_ADC_MEM) ? e_f.carry_flag : 1'b0;
      is_mem = op inside {OP_ADC_MEM, OP_ADD_MEM, OP_AND_MEM};
      wc = wr_cnt;
      if (op inside {OP_AND_ACC, OP_AND_IMM, OP_AND_MEM})
         r = e_acc & b;
      else
      begin
         s = {1'b0, e_acc} + {1'b0, b} + cin;
         lo = {1'b0, e_acc[6:0]} + {1'b0, b[6:0]} + cin;
         h = {1'b0, e_acc[3:0]} + {1'b0, b[3:0]} + cin;
         r = s[7:0];
         e_f.carry_flag = s[8];
         e_f.half_carry_flag = h[4];
         e_f.overflow_flag = lo[7] ^ s[8];
      end
      e_f.zero_flag = (r == 8'h00);
      if (!is_mem)
         e_acc = r;
      issue(op, m, x, 1'b0);
      `CHK(mem_wr, is_mem)
      if (is_mem)
         `CHK(wdata, r)
      `CHK(acc, e_acc)
      `CHK(flags, e_f)
      // Idle cycle: valid never toggles twice in one time step
      @(negedge clk);
      `CHK(mem_wr, 1'b0)
      `CHK(wr_cnt, is_mem ? wc + 1 : wc)
      if (is_mem)
         `CHK(stored, r)
   endtask : arith

   // Skip and program counter writes; a request during busy is dropped
   task automatic t_cycles;
      req_valid = 1'b1;
      req = '{OP_SKIP, 8'h00, 8'h00, 1'b1};
      @(negedge clk);
      `CHK(busy, 1'b1)
      req = '{OP_ADD_IMM, 8'h00, 8'h01, 1'b0};
      @(negedge clk);
      req_valid = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(acc, e_acc)
      @(negedge clk);
      issue(OP_SKIP, 8'h00, 8'h00, 1'b0);
      `CHK(busy, 1'b0)
      @(negedge clk);
      req_valid = 1'b1;
      req = '{OP_PCLOW_WR, 8'h00, 8'h00, 1'b0};
      @(negedge clk);
      `CHK(busy, 1'b1)
      req = '{OP_ADD_IMM, 8'h00, 8'h01, 1'b0};
      @(negedge clk);
      req_valid = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(acc, e_acc)
   endtask : t_cycles

   // Clock enable low: a request must leave acc, flags and mem_wr frozen
   task automatic t_freeze;
      @(negedge clk);
      clk_en = 1'b0;
      req_valid = 1'b1;
      req = '{OP_ADD_MEM, 8'h11, 8'h00, 1'b0};
      @(negedge clk);
      req_valid = 1'b0;
      `CHK(mem_wr, 1'b0)
      `CHK(flags, e_f)
      @(negedge clk);
      clk_en = 1'b1;
      `CHK(acc, e_acc)
   endtask : t_freeze

   task automatic t_wdt(input alu_op_e a, b, input logic gap, other, clr);
      arith(OP_ADD_IMM, 8'h00, 8'h00);
      set_to = 1'b1;
      set_pd = 1'b1;
      @(negedge clk);
      set_to = 1'b0;
      set_pd = 1'b0;
      @(negedge clk);
      // Valid stays high between back-to-back requests
      req_valid = 1'b1;
      req = '{a, 8'h00, 8'h00, 1'b0};
      @(negedge clk);
      if (gap)
      begin
         req_valid = 1'b0;
         @(negedge clk);
         req_valid = 1'b1;
      end
      if (other)
      begin
         req = '{OP_ADD_IMM, 8'h00, 8'h00, 1'b0};
         @(negedge clk);
      end
      req = '{b, 8'h00, 8'h00, 1'b0};
      @(negedge clk);
      req_valid = 1'b0;
      `CHK(wdt_clr, clr)
      `CHK(to_f, !clr)
      `CHK(pd_f, !clr)
      @(negedge clk);
      `CHK(wdt_clr, 1'b0)
   endtask : t_wdt

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Generous ceiling: the sequence needs well under 200 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   initial
   begin
      {rst_b, req_valid, set_to, set_pd} = '0;
      clk_en = 1'b1;
      req = '{OP_NONE, 8'h00, 8'h00, 1'b0};
      e_acc = 8'h00;
      e_f = '0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      arith(OP_ADD_IMM, 8'h00, 8'h7F);
      arith(OP_ADD_ACC, 8'h01, 8'h00);
      arith(OP_ADD_ACC, 8'h80, 8'h00);
      arith(OP_ADC_ACC, 8'h0F, 8'h00);
      arith(OP_ADD_IMM, 8'h00, 8'hF0);
      arith(OP_ADC_MEM, 8'hFF, 8'h00);
      arith(OP_ADD_IMM, 8'h00, 8'h3C);
      arith(OP_ADD_MEM, 8'hC4, 8'h00);
      arith(OP_ADC_ACC, 8'h00, 8'h00);
      arith(OP_AND_IMM, 8'h00, 8'hF0);
      arith(OP_AND_ACC, 8'h0F, 8'h00);
      arith(OP_ADD_IMM, 8'h00, 8'hA5);
      arith(OP_AND_MEM, 8'h5A, 8'h00);
      t_cycles();
      t_freeze();
      t_wdt(OP_WDT_PRE1, OP_WDT_PRE2, 1'b0, 1'b0, 1'b1);
      t_wdt(OP_WDT_PRE2, OP_WDT_PRE1, 1'b0, 1'b0, 1'b1);
      t_wdt(OP_WDT_PRE2, OP_WDT_PRE1, 1'b1, 1'b0, 1'b1);
      t_wdt(OP_WDT_PRE1, OP_WDT_PRE1, 1'b0, 1'b0, 1'b0);
      t_wdt(OP_WDT_PRE1, OP_WDT_PRE2, 1'b0, 1'b1, 1'b0);
      end_sim();
   end
endmodule : tb
